//--- pkg/uwbd_consts.svh
// offsets, field positions, reset values and decode constants of the upstream windows
`ifndef UWBD_CONSTS_SVH
`define UWBD_CONSTS_SVH
`define UWBD_OFF_WIN_ONE   12'h058
`define UWBD_OFF_WIN_TWO   12'h05C
`define UWBD_REG_RST       32'h00000000
`define UWBD_BIT_SPACE     0
`define UWBD_BIT_PREF      3
`define UWBD_BIT_EN        31
`define UWBD_BIT_LUT_OK    0
`define UWBD_TYPE_32       2'h0
`define UWBD_TYPE_64       2'h1
`define UWBD_W1_BASE_LSB   6
`define UWBD_W1_MEM_LSB    12
`define UWBD_W1_IO_LSB     8
`define UWBD_W2_BASE_SH    6'h0E
`define UWBD_PAGE_SH       6'h08
`define UWBD_PAGE_CODE_MAX 5'h11
`endif

//--- pkg/uwbd_pkg.sv
// types shared by the upstream window decode block
package uwbd_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } uwbd_apb_req_type;
   typedef struct packed {
      logic        valid;
      logic        io;
      logic [31:0] addr;
   } uwbd_up_req_type;
   typedef enum logic [1:0] {WIN_NONE, WIN_ONE, WIN_TWO} uwbd_win_type;
   typedef struct packed {
      logic         valid;
      logic         claim;
      uwbd_win_type win;
      logic [31:0]  addr;
   } uwbd_resp_type;
endpackage : uwbd_pkg

//--- rtl/uwbd_top.sv
// upstream base-address windows one and two: apb registers, decode and translation
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uwbd_consts.svh"

module uwbd_top #(
   parameter logic W2_PREFETCH = 1'b0
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_i,
   input  wire uwbd_pkg::uwbd_apb_req_type apb_i,
   output var  logic                     pready_o,
   output var  logic [31:0]              prdata_o,
   output var  logic                     pslverr_o,
   input  wire logic [31:0]              w1_setup_i,
   input  wire logic [31:0]              w1_xlat_base_i,
   input  wire logic [4:0]               w2_page_code_i,
   input  wire uwbd_pkg::uwbd_up_req_type req_i,
   output var  logic [5:0]               lut_index_o,
   input  wire logic [31:0]              lut_entry_i,
   output var  uwbd_pkg::uwbd_resp_type  resp_o
);

   // register state
   logic [31:0] base1_r;
   logic [31:0] base1_nxt;
   logic [31:0] base2_r;
   logic [31:0] base2_nxt;
   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;

   // pipeline state
   logic        s1_vld_r;
   logic        s1_hit1_r;
   logic        s1_hit2_r;
   logic [31:0] s1_addr_r;
   logic [31:0] s1_xlat1_r;
   logic [31:0] s1_pmask_r;
   logic [5:0]  lut_idx_r;
   uwbd_pkg::uwbd_resp_type resp_r;
   uwbd_pkg::uwbd_resp_type resp_nxt;

   // window one size: setup bits pick writable base bits
   wire        w1_en     = w1_setup_i[`UWBD_BIT_EN];
   wire        w1_io     = w1_setup_i[`UWBD_BIT_SPACE];
   wire [25:0] w1_mem_m  = {w1_setup_i[31:`UWBD_W1_MEM_LSB], 6'h00};
   wire [25:0] w1_io_m   = {24'hFFFFFF, w1_setup_i[7:`UWBD_W1_BASE_LSB]};
   wire [25:0] w1_sel_m  = w1_io ? w1_io_m : w1_mem_m;
   wire [25:0] w1_mask26 = w1_en ? w1_sel_m : 26'h0000000;
   wire [31:0] w1_mask   = {w1_mask26, 6'h00};
   wire [31:0] base1_eff = base1_r & w1_mask;
   wire [31:0] w1_xlat_m = w1_xlat_base_i & w1_mask;
   wire [1:0]  w1_type   = (w1_setup_i[2:1] == `UWBD_TYPE_64 && !w1_io) ?
                           `UWBD_TYPE_64 : `UWBD_TYPE_32;
   wire        w1_pref   = w1_setup_i[`UWBD_BIT_PREF] & ~w1_io;

   // window two size: page code clamps at 32MB pages, a 2GB window
   wire [4:0]  w2_code   = (w2_page_code_i > `UWBD_PAGE_CODE_MAX) ?
                           `UWBD_PAGE_CODE_MAX : w2_page_code_i;
   wire [5:0]  w2_sh     = `UWBD_W2_BASE_SH + {1'b0, w2_code};
   wire [5:0]  pg_sh     = `UWBD_PAGE_SH + {1'b0, w2_code};
   wire [31:0] w2_mask   = 32'hFFFFFFFF << w2_sh;
   wire [31:0] pg_mask   = 32'hFFFFFFFF << pg_sh;
   wire [31:0] base2_eff = base2_r & w2_mask;

   // readback: reserved bits are constant zero, never stored
   wire [31:0] w1_rd = base1_eff |
                       {28'h0000000, w1_pref, w1_type, 1'b0};
   wire [31:0] w2_rd = base2_eff |
                       {28'h0000000, W2_PREFETCH, `UWBD_TYPE_32, 1'b0};

   // apb decode; one wait state keeps pready and prdata flopped
   wire hit_w1   = (apb_i.paddr == `UWBD_OFF_WIN_ONE);
   wire hit_w2   = (apb_i.paddr == `UWBD_OFF_WIN_TWO);
   wire mapped   = hit_w1 | hit_w2;
   wire acc      = apb_i.psel & apb_i.penable;
   wire acc_first = acc & ~pready_r;
   wire acc_done = acc & pready_r;
   wire wr_done  = acc_done & apb_i.pwrite;
   wire [31:0] rd_mux = hit_w1 ? w1_rd : (hit_w2 ? w2_rd : 32'h00000000);

   // write merge: only writable bits take new data
   assign base1_nxt = (wr_done && hit_w1) ?
                      ((apb_i.pwdata & w1_mask) | (base1_r & ~w1_mask)) : base1_r;
   assign base2_nxt = (wr_done && hit_w2) ?
                      ((apb_i.pwdata & w2_mask) | (base2_r & ~w2_mask)) : base2_r;

   // base registers clear on bridge reset, so both windows start closed
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         base1_r <= `UWBD_REG_RST;
         base2_r <= `UWBD_REG_RST;
      end
      else
      begin
         base1_r <= base1_nxt;
         base2_r <= base2_nxt;
      end
   end

   // apb answer flops
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r  <= acc_first;
         prdata_r  <= (acc_first && !apb_i.pwrite) ? rd_mux : 32'h00000000;
         pslverr_r <= acc_first & ~mapped;
      end
   end

   // stage one: match both windows, pick the lookup page
   wire [31:0] rq_a    = req_i.addr;
   wire        w1_live = w1_en && (base1_eff != 32'h00000000);
   wire        w2_live = (base2_eff != 32'h00000000);
   wire        m1      = ((rq_a & w1_mask) == base1_eff) && (req_i.io == w1_io);
   wire        m2      = ((rq_a & w2_mask) == base2_eff) && !req_i.io;
   wire [31:0] pg_sel  = rq_a >> pg_sh;
   wire [31:0] xlat1   = w1_xlat_m | (rq_a & ~w1_mask);

   // stage one flops; lookup index leaves a cycle ahead of the response
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_vld_r   <= 1'b0;
         s1_hit1_r  <= 1'b0;
         s1_hit2_r  <= 1'b0;
         s1_addr_r  <= 32'h00000000;
         s1_xlat1_r <= 32'h00000000;
         s1_pmask_r <= 32'h00000000;
         lut_idx_r  <= 6'h00;
      end
      else
      begin
         s1_vld_r   <= req_i.valid;
         s1_hit1_r  <= req_i.valid & w1_live & m1;
         s1_hit2_r  <= req_i.valid & w2_live & m2;
         s1_addr_r  <= rq_a;
         s1_xlat1_r <= xlat1;
         s1_pmask_r <= pg_mask;
         lut_idx_r  <= pg_sel[5:0];
      end
   end

   // stage two: window one wins overlap; a dead page never claims
   wire        pg_ok  = lut_entry_i[`UWBD_BIT_LUT_OK];
   wire        hit2_ok = s1_hit2_r & pg_ok;
   wire [31:0] xlat2  = (lut_entry_i & s1_pmask_r) |
                        (s1_addr_r & ~s1_pmask_r);

   always_comb
   begin
      resp_nxt       = '0;
      resp_nxt.valid = s1_vld_r;
      resp_nxt.win   = uwbd_pkg::WIN_NONE;
      resp_nxt.addr  = s1_addr_r;
      if (s1_hit1_r)
      begin
         resp_nxt.claim = 1'b1;
         resp_nxt.win   = uwbd_pkg::WIN_ONE;
         resp_nxt.addr  = s1_xlat1_r;
      end
      else if (hit2_ok)
      begin
         resp_nxt.claim = 1'b1;
         resp_nxt.win   = uwbd_pkg::WIN_TWO;
         resp_nxt.addr  = xlat2;
      end
   end

   // response flop
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         resp_r <= '0;
      else
         resp_r <= resp_nxt;
   end

   // outputs straight from flops
   assign pready_o    = pready_r;
   assign prdata_o    = prdata_r;
   assign pslverr_o   = pslverr_r;
   assign lut_index_o = lut_idx_r;
   assign resp_o      = resp_r;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // read completion: the edge at which the master takes prdata
   wire rd_end = pready_r & acc & ~apb_i.pwrite;

   // plain copies for $past, which wants whole signals
   wire        rq_io  = req_i.io;
   wire [31:0] wdat   = apb_i.pwdata;
   wire [5:0]  pg_at0 = rq_a[13:8];

   space_bit_zero_a: assert property (
      rd_end |-> (prdata_r[`UWBD_BIT_SPACE] == 1'b0))
      else $error("space bit read as io");

   w1_type_legal_a: assert property (
      (rd_end && hit_w1) |-> (prdata_r[2:1] == `UWBD_TYPE_32 ||
                              prdata_r[2:1] == `UWBD_TYPE_64))
      else $error("window one type reserved code");

   w2_type_fixed_a: assert property (
      (rd_end && hit_w2) |-> (prdata_r[2:1] == `UWBD_TYPE_32))
      else $error("window two type not 32-bit");

   reserved_zero_a: assert property (
      rd_end |-> (hit_w1 ? (prdata_r[5:4] == 2'h0) : (prdata_r[13:4] == 10'h000)))
      else $error("reserved bits nonzero");

   w1_mask_hold_a: assert property (
      (wr_done && hit_w1) |=> (((base1_r ^ $past(base1_r)) & ~$past(w1_mask))
                               == 32'h00000000))
      else $error("read-only base bit changed");

   w2_mask_hold_a: assert property (
      (wr_done && hit_w2) |=> (((base2_r ^ $past(base2_r)) & ~$past(w2_mask))
                               == 32'h00000000))
      else $error("window two read-only bit changed");

   w1_enable_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_ONE) |-> $past(w1_en, 2))
      else $error("disabled window one claimed");

   zero_base_a: assert property (
      (req_i.valid && !w1_live && !w2_live) |-> ##2 !resp_r.claim)
      else $error("closed windows claimed");

   page_gate_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_TWO) |-> $past(pg_ok))
      else $error("disabled page claimed");

   w1_xlat_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_ONE) |->
         ((resp_r.addr & $past(w1_mask, 2)) == $past(w1_xlat_m, 2)))
      else $error("window one translation wrong");

   claim_lat_a: assert property (
      req_i.valid |-> ##2 resp_r.valid)
      else $error("response not two cycles after request");

   apb_ready_a: assert property (
      acc_first |=> (pready_r ##1 !pready_r))
      else $error("pready not a single cycle");

   rdata_idle_a: assert property (
      !pready_r |-> (prdata_r == 32'h00000000 && !pslverr_r))
      else $error("apb answer outside ready cycle");

   unmapped_err_a: assert property (
      (acc_first && !mapped) |=> (pready_r && pslverr_r))
      else $error("unmapped access without error");

   mapped_ok_a: assert property (
      (acc_first && mapped) |=> !pslverr_r)
      else $error("mapped access flagged as error");

   w1_write_a: assert property (
      (wr_done && hit_w1) |=> ((base1_r & $past(w1_mask)) ==
                               ($past(wdat) & $past(w1_mask))))
      else $error("window one writable bit lost write");

   w2_write_a: assert property (
      (wr_done && hit_w2) |=> ((base2_r & $past(w2_mask)) ==
                               ($past(wdat) & $past(w2_mask))))
      else $error("window two writable bit lost write");

   w1_claim_a: assert property (
      (req_i.valid && w1_live && m1) |->
         ##2 (resp_r.claim && resp_r.win == uwbd_pkg::WIN_ONE))
      else $error("window one hit not claimed");

   w2_claim_a: assert property (
      (req_i.valid && w2_live && m2 && !(w1_live && m1)) ##1 pg_ok |=>
         (resp_r.claim && resp_r.win == uwbd_pkg::WIN_TWO))
      else $error("window two live page not claimed");

   page_index_a: assert property (
      (req_i.valid && w2_page_code_i == 5'h00) |=> (lut_idx_r == $past(pg_at0)))
      else $error("lookup index not the page number");

   w2_xlat_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_TWO) |->
         (resp_r.addr == (($past(lut_entry_i) & $past(pg_mask, 2)) |
                          ($past(rq_a, 2) & ~$past(pg_mask, 2)))))
      else $error("window two translation wrong");

   w2_mem_only_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_TWO) |-> !$past(rq_io, 2))
      else $error("io request claimed by window two");

   w1_space_a: assert property (
      (resp_r.claim && resp_r.win == uwbd_pkg::WIN_ONE) |->
         ($past(rq_io, 2) == $past(w1_io, 2)))
      else $error("window one claimed wrong space");

   miss_pass_a: assert property (
      (resp_r.valid && !resp_r.claim) |->
         (resp_r.win == uwbd_pkg::WIN_NONE && resp_r.addr == $past(rq_a, 2)))
      else $error("missed request altered");

   claim_valid_a: assert property (
      resp_r.claim |-> resp_r.valid)
      else $error("claim without valid response");

   w1_closed_a: assert property (
      (req_i.valid && !w1_live) |-> ##2 (resp_r.win != uwbd_pkg::WIN_ONE))
      else $error("closed window one claimed");

   w2_closed_a: assert property (
      (req_i.valid && !w2_live) |-> ##2 (resp_r.win != uwbd_pkg::WIN_TWO))
      else $error("closed window two claimed");

endmodule : uwbd_top
`default_nettype wire

//--- sim/uwbd_lut_model.sv
// lookup table model standing behind the window two page lookup
`timescale 1ns/1ps
`default_nettype none
module uwbd_lut_model (
   input  wire logic [5:0]  index_i,
   output var  logic [31:0] entry_o
);
   // page 3 left invalid so a hole inside the window gets exercised
   assign entry_o = {24'hC00000, 7'h00, index_i != 6'h03};
endmodule : uwbd_lut_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the upstream window decode block
`timescale 1ns/1ps
`default_nettype none
`include "uwbd_consts.svh"
module testbench;
   logic                       clk;
   logic                       rst;
   uwbd_pkg::uwbd_apb_req_type apb;
   uwbd_pkg::uwbd_up_req_type  req;
   uwbd_pkg::uwbd_resp_type    resp;
   logic                       rdy, serr;
   logic [31:0]                rdata, setup, xlat, entry, t1, wd, e1, e2, d;
   logic [4:0]                 code, tc;
   logic [5:0]                 idx;
   logic                       x;
   int                         num_errors, tests_run, cycles;
   logic [132:0]               rrow [6];
   logic [67:0]                drow [6];

   uwbd_top dut_u (
      .ref_clk_i(clk), .rst_i(rst), .apb_i(apb), .pready_o(rdy), .prdata_o(rdata),
      .pslverr_o(serr), .w1_setup_i(setup), .w1_xlat_base_i(xlat),
      .w2_page_code_i(code), .req_i(req), .lut_index_o(idx), .lut_entry_i(entry),
      .resp_o(resp));
   uwbd_lut_model lut_u (.index_i(idx), .entry_o(entry));

   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; waits for pready with no assumed latency
   task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] wdat,
                           output logic [31:0] rd, output logic er);
      @(posedge clk);
      apb <= '{1'b1, 1'b0, w, a, wdat};
      @(posedge clk);
      apb.penable <= 1'b1;
      do
         @(posedge clk);
      while (rdy !== 1'b1);
      rd = rdata;
      er = serr;
      apb <= '0;
   endtask : apb_xfer

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb_xfer(1'b0, a, 32'h00000000, d, x);
      chk(d, e);
      chk({31'h0, x}, 32'h00000000);
   endtask : rd_chk

   // request: {io, addr, claim, win, translated addr}
   task automatic send(input logic [67:0] r);
      @(posedge clk);
      req <= {1'b1, r[67:35]};
      @(posedge clk);
      req.valid <= 1'b0;
      @(negedge clk);
      if (r[66:49] == 18'h10000)
         chk({26'h0, idx}, {26'h0, r[48:43]});
      @(negedge clk);
      chk({31'h0, resp.valid}, 32'h00000001);
      chk({31'h0, resp.claim}, {31'h0, r[34]});
      chk({30'h0, resp.win}, {30'h0, r[33:32]});
      chk(resp.addr, r[31:0]);
   endtask : send

   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // rows: setup, page code, write data, window one and two readback
   initial
   begin
      rrow = '{{32'hFFFFF00A, 5'h00, 32'hFFFFFFFF, 32'hFFFFF00A, 32'hFFFFC000},
               {32'h80000000, 5'h11, 32'hFFFFFFFF, 32'h80000000, 32'h80000000},
               {32'h800000C1, 5'h05, 32'hFFFFFFFF, 32'hFFFFFFC0, 32'hFFF80000},
               {32'h80000001, 5'h1F, 32'hFFFFFFFF, 32'hFFFFFF00, 32'h80000000},
               {32'h7FFFF000, 5'h00, 32'h12345678, 32'h00000000, 32'h12344000},
               {32'hFFFFF004, 5'h02, 32'hABCDEF3F, 32'hABCDE000, 32'hABCD0000}};
      drow = '{{1'b0, 32'h12345678, 1'b1, 2'h1, 32'hA0000678},
               {1'b1, 32'h12345678, 1'b0, 2'h0, 32'h12345678},
               {1'b0, 32'h12346678, 1'b0, 2'h0, 32'h12346678},
               {1'b0, 32'h40000578, 1'b1, 2'h2, 32'hC0000078},
               {1'b0, 32'h40000378, 1'b0, 2'h0, 32'h40000378},
               {1'b0, 32'h40003F10, 1'b1, 2'h2, 32'hC0000010}};
      clk = 1'b0;
      rst = 1'b1;
      apb = '0;
      req = '0;
      setup = 32'h00000000;
      xlat = 32'h00000000;
      code = 5'h00;
      num_errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(`UWBD_OFF_WIN_ONE, 32'h00000000);
      rd_chk(`UWBD_OFF_WIN_TWO, 32'h00000000);
      for (int i = 0; i < 6; i++)
      begin
         {t1, tc, wd, e1, e2} = rrow[i];
         setup <= t1;
         code <= tc;
         apb_xfer(1'b1, `UWBD_OFF_WIN_ONE, wd, d, x);
         apb_xfer(1'b1, `UWBD_OFF_WIN_TWO, wd, d, x);
         rd_chk(`UWBD_OFF_WIN_ONE, e1);
         rd_chk(`UWBD_OFF_WIN_TWO, e2);
      end
      apb_xfer(1'b1, 12'h060, 32'hFFFFFFFF, d, x);
      apb_xfer(1'b0, 12'h060, 32'h00000000, d, x);
      chk(d, 32'h00000000);
      chk({31'h0, x}, 32'h00000001);
      setup <= 32'hFFFFF000;
      code <= 5'h00;
      xlat <= 32'hA0000000;
      apb_xfer(1'b1, `UWBD_OFF_WIN_ONE, 32'h12345000, d, x);
      apb_xfer(1'b1, `UWBD_OFF_WIN_TWO, 32'h40000000, d, x);
      foreach (drow[i])
         send(drow[i]);
      @(posedge clk);
      setup <= 32'h7FFFF000;
      send({1'b0, 32'h12345678, 1'b0, 2'h0, 32'h12345678});
      @(posedge clk);
      setup <= 32'hFFFFF000;
      apb_xfer(1'b1, `UWBD_OFF_WIN_ONE, 32'h00000000, d, x);
      send({1'b0, 32'h00000678, 1'b0, 2'h0, 32'h00000678});
      // io window of 64 bytes, hit by an io request
      @(posedge clk);
      setup <= 32'h800000C1;
      apb_xfer(1'b1, `UWBD_OFF_WIN_ONE, 32'h00000F40, d, x);
      send({1'b1, 32'h00000F57, 1'b1, 2'h1, 32'hA0000017});
      @(posedge clk);
      setup <= 32'hFFFFF000;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(`UWBD_OFF_WIN_ONE, 32'h00000000);
      rd_chk(`UWBD_OFF_WIN_TWO, 32'h00000000);
      // both bases cleared: an address that matches them must not be claimed
      send({1'b0, 32'h00000000, 1'b0, 2'h0, 32'h00000000});
      end_sim();
   end
endmodule : testbench
`default_nettype wire
